/* shared/e3_gc_pkg.sv */
// Shared constants for the E3 transmit payload input and channel byte path.
// Assumes a 100 MHz system clock and byte-addressed classic Wishbone.
package e3_gc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] RX_NR_IDX   = 6'h1A;
  localparam logic [5:0] RX_GC_IDX   = 6'h1B;
  localparam logic [5:0] CTRL_IDX    = 6'h30;
  localparam logic [5:0] STATUS_IDX  = 6'h31;
  localparam logic [5:0] TX_GC_IDX   = 6'h35;
  localparam logic [5:0] TX_NR_IDX   = 6'h37;

  // Control register fields
  localparam int CTRL_LOCAL_BIT  = 0;
  localparam int CTRL_LAPD_GC    = 1;
  localparam int CTRL_LAPD_NR    = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Status register fields (write one to clear)
  localparam int STAT_OVERRUN  = 0;
  localparam int STAT_UNDERRUN = 1;

  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [7:0] LAPD_IDLE = 8'h7E;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [7:0] FA1_VAL   = 8'hF6;
  localparam logic [7:0] FA2_VAL   = 8'h28;

  // Frame geometry: 537 bytes of 8 bits
  localparam logic [12:0] FRAME_BITS = 13'd4296;
  localparam logic [12:0] LAST_BIT   = 13'd4295;
  localparam logic [9:0]  FA1_POS    = 10'd0;
  localparam logic [9:0]  FA2_POS    = 10'd1;
  localparam logic [9:0]  EM_POS     = 10'd60;
  localparam logic [9:0]  TR_POS     = 10'd120;
  localparam logic [9:0]  MA_POS     = 10'd180;
  localparam logic [9:0]  NR_POS     = 10'd240;
  localparam logic [9:0]  GC_POS     = 10'd300;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

endpackage

/* core/payload_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module payload_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

/* core/e3_tx_payload_input.sv */
// Transmit payload input interface of an E3 framer with the general
// communications byte path and its Wishbone register file.
// Assumes link clocks well below half of clk_i; the terminal side input pins are asynchronous.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Either the general channel byte or the network operator byte can carry one LAPD octet per frame.
// [R2] Without LAPD the general channel byte of every frame takes the transmit register value.
// [R3] The general channel byte of each received frame is stored in the receive register.
// [R4] In serial mode the payload bit is sampled on the rising edge of the selected clock.
// [R5] The serial input is used only while nibble mode is deselected.
// [R6] In nibble mode the nibble bus is sampled on each rising edge of the nibble clock; the code samples it as the nibble clock falls.
// [R7] The nibble bus is used only while nibble mode is selected.
// [R8] With local timing selected the local reference clock samples the serial input.
// [R9] With local timing the far end supplies a continuous 34.368 MHz reference.
// [R10] The nibble clock is derived from the selected timing reference.
// [R11] The overhead warning is high the bit before an overhead bit, whose input is ignored.
// [R12] The end of frame output is high for the bit period of the last frame bit.
// [R13] The LAPD or register choice for the channel bytes changes only at a frame boundary.
module e3_tx_payload_input
  import e3_gc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Terminal side pins
  input  wire logic        tx_local_ref_clock_i,
  input  wire logic        recovered_line_clock_i,
  input  wire logic        nibble_interface_select_i,
  input  wire logic        tx_serial_payload_in_i,
  input  wire logic [3:0]  tx_nibble_payload_in_i,
  output logic             loop_payload_clock_out_o,
  output logic             nibble_sample_clock_out_o,
  output logic             overhead_bit_warning_o,
  output logic             end_of_frame_pulse_o,
  output logic             nibble_frame_boundary_pulse_o,
  // LAPD octet source
  input  wire logic [7:0]  lapd_byte_i,
  input  wire logic        lapd_valid_i,
  output logic             lapd_ready_o,
  // Receive framer capture strobes
  input  wire logic [7:0]  rx_general_channel_byte_i,
  input  wire logic        rx_gc_valid_i,
  input  wire logic [7:0]  rx_nr_byte_i,
  input  wire logic        rx_nr_valid_i,
  // Outbound framed byte stream
  output logic [7:0]       frame_byte_o,
  output logic             frame_byte_valid_o,
  output logic             frame_start_o
);

  function automatic logic is_oh(input logic [9:0] idx);
    is_oh = (idx == FA1_POS) || (idx == FA2_POS) || (idx == EM_POS) ||
            (idx == TR_POS)  || (idx == MA_POS)  || (idx == NR_POS) ||
            (idx == GC_POS);
  endfunction

  function automatic logic [12:0] bit_next(input logic [12:0] b);
    bit_next = (b == LAST_BIT) ? 13'd0 : b + 13'd1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] ref_sync_q;
  logic [1:0] line_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] ser_sync_q;
  logic [3:0] nib_s1_q;
  logic [3:0] nib_s2_q;
  logic       clk_prev_q;
  logic       line_lvl_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_sync_q  <= 2'h0;
      line_sync_q <= 2'h0;
      sel_sync_q  <= 2'h0;
      ser_sync_q  <= 2'h0;
      nib_s1_q    <= 4'h0;
      nib_s2_q    <= 4'h0;
    end
    else
    begin
      ref_sync_q  <= {ref_sync_q[0], tx_local_ref_clock_i};
      line_sync_q <= {line_sync_q[0], recovered_line_clock_i};
      sel_sync_q  <= {sel_sync_q[0], nibble_interface_select_i};
      ser_sync_q  <= {ser_sync_q[0], tx_serial_payload_in_i};
      nib_s1_q    <= tx_nibble_payload_in_i;
      nib_s2_q    <= nib_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [2:0] ctrl_q;
  logic [2:0] act_cfg_q;
  logic [1:0] status_q;
  logic [7:0] tx_gc_q;
  logic [7:0] tx_nr_q;
  logic [7:0] rx_gc_q;
  logic [7:0] rx_nr_q;
  logic       wb_req;
  logic       wb_wr;
  logic [5:0] wb_idx;
  logic       overrun_ev;
  logic       underrun_ev;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  assign wb_idx = wb_adr_i[7:2];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q  <= CTRL_RST;
      tx_gc_q <= BYTE_RST;
      tx_nr_q <= BYTE_RST;
    end
    else if (wb_wr)
    begin
      case (wb_idx)
        CTRL_IDX:  ctrl_q  <= wb_dat_i[2:0];
        TX_GC_IDX: tx_gc_q <= wb_dat_i[7:0];
        TX_NR_IDX: tx_nr_q <= wb_dat_i[7:0];
        default:   ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // Sticky errors; a new event beats a same-cycle clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_q <= 2'h0;
    end
    else
    begin
      status_q <= (status_q & ~((wb_wr && wb_idx == STATUS_IDX) ?
                                wb_dat_i[1:0] : 2'h0))
                  | {underrun_ev, overrun_ev};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_gc_q <= BYTE_RST;
      rx_nr_q <= BYTE_RST;
    end
    else
    begin
      if (rx_gc_valid_i)
      begin
        rx_gc_q <= rx_general_channel_byte_i; // [R3]
      end
      if (rx_nr_valid_i)
      begin
        rx_nr_q <= rx_nr_byte_i;
      end
    end
  end

  // One wait state; unmapped reads return zero, writes are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      case (wb_idx)
        RX_GC_IDX:  wb_dat_o <= {24'h0, rx_gc_q};
        RX_NR_IDX:  wb_dat_o <= {24'h0, rx_nr_q};
        TX_GC_IDX:  wb_dat_o <= {24'h0, tx_gc_q};
        TX_NR_IDX:  wb_dat_o <= {24'h0, tx_nr_q};
        CTRL_IDX:   wb_dat_o <= {29'h0, ctrl_q};
        STATUS_IDX: wb_dat_o <= {30'h0, status_q};
        default:    wb_dat_o <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit timing from the selected reference

  logic        sel_clk;
  logic        bit_tick;
  logic        nib_mode;
  logic [12:0] bit_q;
  logic [12:0] bit_n;
  logic [12:0] bit_nn;

  assign sel_clk  = ctrl_q[CTRL_LOCAL_BIT] ? ref_sync_q[1] // [R8]
                                           : line_sync_q[1];
  assign bit_tick = sel_clk & ~clk_prev_q; // [R4]
  assign nib_mode = sel_sync_q[1];
  assign bit_n    = bit_next(bit_q);
  assign bit_nn   = bit_next(bit_n);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_prev_q <= 1'b0;
      line_lvl_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= sel_clk;
      line_lvl_q <= line_sync_q[1];
    end
  end

  assign loop_payload_clock_out_o = line_lvl_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bit_q <= 13'd0;
    end
    else if (bit_tick)
    begin
      bit_q <= bit_n;
    end
  end

  // End of frame marks one bit period; the nibble frame boundary marks the last four
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overhead_bit_warning_o        <= 1'b0;
      end_of_frame_pulse_o          <= 1'b0;
      nibble_frame_boundary_pulse_o <= 1'b0;
      nibble_sample_clock_out_o     <= 1'b0;
    end
    else if (bit_tick)
    begin
      overhead_bit_warning_o <= is_oh(bit_nn[12:3]); // [R11]
      end_of_frame_pulse_o   <= (bit_n == LAST_BIT); // [R12]
      nibble_frame_boundary_pulse_o <= nib_mode &&
                                       (bit_n[12:2] == LAST_BIT[12:2]);
      // Divide by four; rises on the third bit of each nibble
      nibble_sample_clock_out_o <= nib_mode && bit_n[1]; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Payload capture

  logic       ser_take;
  logic       nib_take;
  logic [7:0] sh_q;
  logic [2:0] fill_q;
  logic       pend_q;
  logic [7:0] pend_byte_q;
  logic       fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic       fifo_out_valid;
  logic       fifo_pop;

  // Overhead slots carry no terminal data
  assign ser_take = bit_tick & ~nib_mode & ~is_oh(bit_q[12:3]); // [R5][R11]
  assign nib_take = bit_tick & nib_mode & (bit_q[1:0] == 2'h3) &
                    ~is_oh(bit_q[12:3]); // [R6][R7]

  // A finished byte waits for FIFO room; a second one while waiting replaces it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh_q        <= 8'h00;
      fill_q      <= 3'h0;
      pend_q      <= 1'b0;
      pend_byte_q <= 8'h00;
      overrun_ev  <= 1'b0;
    end
    else
    begin
      overrun_ev <= 1'b0;
      if (pend_q && fifo_in_ready)
      begin
        pend_q <= 1'b0;
      end
      if (ser_take)
      begin
        sh_q   <= {sh_q[6:0], ser_sync_q[1]};
        fill_q <= fill_q + 3'h1;
        if (fill_q == 3'h7)
        begin
          overrun_ev  <= pend_q & ~fifo_in_ready;
          pend_q      <= 1'b1;
          pend_byte_q <= {sh_q[6:0], ser_sync_q[1]};
        end
      end
      else if (nib_take)
      begin
        sh_q   <= {sh_q[3:0], nib_s2_q};
        fill_q <= fill_q + 3'h4;
        if (fill_q == 3'h4)
        begin
          overrun_ev  <= pend_q & ~fifo_in_ready;
          pend_q      <= 1'b1;
          pend_byte_q <= {sh_q[3:0], nib_s2_q};
        end
      end
    end
  end

  payload_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (pend_byte_q),
    .in_valid_i  (pend_q),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outbound byte assembly

  logic       slot_end;
  logic [9:0] slot;
  logic       slot_oh;
  logic       gc_lapd;
  logic       nr_lapd;
  logic       lapd_slot;
  logic [7:0] oh_byte;

  assign slot_end  = bit_tick & (bit_q[2:0] == 3'h7);
  assign slot      = bit_q[12:3];
  assign slot_oh   = is_oh(slot);
  assign gc_lapd   = act_cfg_q[CTRL_LAPD_GC];
  assign nr_lapd   = act_cfg_q[CTRL_LAPD_NR] & ~gc_lapd;
  assign lapd_slot = (slot == GC_POS && gc_lapd) ||
                     (slot == NR_POS && nr_lapd); // [R1]
  assign fifo_pop     = slot_end & ~slot_oh;
  assign lapd_ready_o = slot_end & lapd_slot;

  // Channel byte choice is reloaded only at the last frame bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act_cfg_q <= CTRL_RST;
    end
    else if (bit_tick && bit_q == LAST_BIT)
    begin
      act_cfg_q <= ctrl_q; // [R13]
    end
  end

  always_comb
  begin
    oh_byte = 8'h00;
    if (lapd_slot)
    begin
      oh_byte = lapd_valid_i ? lapd_byte_i : LAPD_IDLE;
    end
    else if (slot == GC_POS)
    begin
      oh_byte = tx_gc_q; // [R2]
    end
    else if (slot == NR_POS)
    begin
      oh_byte = tx_nr_q;
    end
    else if (slot == FA1_POS)
    begin
      oh_byte = FA1_VAL;
    end
    else if (slot == FA2_POS)
    begin
      oh_byte = FA2_VAL;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_byte_o       <= 8'h00;
      frame_byte_valid_o <= 1'b0;
      frame_start_o      <= 1'b0;
      underrun_ev        <= 1'b0;
    end
    else
    begin
      frame_byte_valid_o <= slot_end;
      frame_start_o      <= slot_end && (slot == FA1_POS);
      underrun_ev        <= fifo_pop & ~fifo_out_valid;
      if (slot_end)
      begin
        if (slot_oh)
        begin
          frame_byte_o <= oh_byte;
        end
        else
        begin
          frame_byte_o <= fifo_out_valid ? fifo_out_data : FILL_BYTE;
        end
      end
    end
  end

endmodule

/* tb/e3_tx_payload_input_properties.sv */
// Port-level checks for the transmit payload input block.
// Assumes it is bound to e3_tx_payload_input.
`timescale 1ns/1ps
module payload_input_props
  import e3_gc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        nibble_interface_select_i,
  input wire logic        nibble_sample_clock_out_o,
  input wire logic        overhead_bit_warning_o,
  input wire logic        end_of_frame_pulse_o,
  input wire logic [7:0]  lapd_byte_i,
  input wire logic        lapd_valid_i,
  input wire logic        lapd_ready_o,
  input wire logic [7:0]  frame_byte_o,
  input wire logic        frame_byte_valid_o,
  input wire logic        frame_start_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  logic mapped;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign mapped = wb_adr_i[7:2] inside {RX_NR_IDX, RX_GC_IDX, CTRL_IDX,
                                        STATUS_IDX, TX_GC_IDX, TX_NR_IDX};
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_unmapped_zero: assert property (
    req && !wb_we_i && !mapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_lapd_insert: assert property (lapd_ready_o |=> frame_byte_valid_o &&
    frame_byte_o == ($past(lapd_valid_i) ? $past(lapd_byte_i) : LAPD_IDLE))
    else $error("lapd octet not sent");
  // Sync plus one bit period must pass before the clock output settles
  logic [4:0] ser_cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || nibble_interface_select_i)
    begin
      ser_cnt_q <= 5'h00;
    end
    else if (ser_cnt_q != 5'h1F)
    begin
      ser_cnt_q <= ser_cnt_q + 5'h01;
    end
  end
  a_nib_idle: assert property (
    ser_cnt_q >= 5'h10 |-> !nibble_sample_clock_out_o)
    else $error("nibble clock in serial mode");
  a_eof_warns: assert property (
    end_of_frame_pulse_o |-> overhead_bit_warning_o)
    else $error("no warning before frame start");
  a_fa1_start: assert property (frame_start_o |->
    frame_byte_valid_o && frame_byte_o == FA1_VAL)
    else $error("frame start without alignment byte");
  a_eof_restart: assert property (
    $fell(end_of_frame_pulse_o) |-> ##[1:1000] frame_start_o)
    else $error("no frame after end pulse");
  a_valid_pulse: assert property (
    frame_byte_valid_o |=> !frame_byte_valid_o)
    else $error("byte strobe held");
  c_lapd: cover property (lapd_ready_o);
  c_eof: cover property ($fell(end_of_frame_pulse_o));
  c_nib: cover property ($rose(nibble_sample_clock_out_o));
endmodule

bind e3_tx_payload_input payload_input_props props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .nibble_interface_select_i(nibble_interface_select_i),
  .nibble_sample_clock_out_o(nibble_sample_clock_out_o),
  .overhead_bit_warning_o(overhead_bit_warning_o),
  .end_of_frame_pulse_o(end_of_frame_pulse_o), .lapd_byte_i(lapd_byte_i),
  .lapd_valid_i(lapd_valid_i), .lapd_ready_o(lapd_ready_o),
  .frame_byte_o(frame_byte_o), .frame_byte_valid_o(frame_byte_valid_o),
  .frame_start_o(frame_start_o));

/* tb/terminal_model.sv */
// Terminal equipment model: link clock pins and payload pins.
// Assumes bit 0 of the block is the first link edge after run_i.
`timescale 1ns/1ps
module terminal_model (
  input  wire logic       run_i,
  input  wire logic       use_local_i,
  input  wire logic       nib_mode_i,
  output logic            link_clk_o,
  output logic            local_clk_o,
  output logic            line_clk_o,
  output logic            ser_o,
  output logic [3:0]      nib_o
);
  localparam logic [7:0] PAT = 8'hA5;
  int unsigned k_q;
  int unsigned n_q;
  logic        bit_v;
  logic [3:0]  nib_v;
  // Phase offset keeps link edges apart from system clock edges
  initial
  begin
    link_clk_o = 1'b0;
    #3;
    forever #40 link_clk_o = run_i & ~link_clk_o;
  end
  assign local_clk_o = link_clk_o & use_local_i;
  assign line_clk_o = link_clk_o & ~use_local_i;
  always @(posedge link_clk_o) k_q <= k_q + 1;
  // Data moves on the falling edge, clear of the sampling edge
  always @(negedge link_clk_o) n_q <= k_q;
  assign bit_v = PAT[3'd7 - n_q[2:0]];
  assign nib_v = n_q[2] ? PAT[3:0] : PAT[7:4];
  // Unused pins carry inverted data so a wrong choice shows
  assign ser_o = nib_mode_i ? ~bit_v : bit_v;
  assign nib_o = nib_mode_i ? nib_v : ~nib_v;
endmodule

/* tb/tb.sv */
// Self-checking bench for the transmit payload input block.
// Assumes terminal_model on the link pins and the bound checker.
`timescale 1ns/1ps
module tb
  import e3_gc_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, run = 1'b0, loc = 1'b0, nsel = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, dat_o;
  logic [7:0] gbyte = 8'h00, nbyte = 8'h00, fbyte;
  logic gval = 1'b0, nval = 1'b0, lval = 1'b1, lrdy, fval, fstart;
  logic lclk, lref, lline, ser, lpclk, nclk, warn, eof, nfr;
  logic [3:0] nib;
  int error_cnt = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  e3_tx_payload_input dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tx_local_ref_clock_i(lref), .recovered_line_clock_i(lline),
    .nibble_interface_select_i(nsel), .tx_serial_payload_in_i(ser),
    .tx_nibble_payload_in_i(nib), .loop_payload_clock_out_o(lpclk),
    .nibble_sample_clock_out_o(nclk), .overhead_bit_warning_o(warn),
    .end_of_frame_pulse_o(eof), .nibble_frame_boundary_pulse_o(nfr),
    .lapd_byte_i(8'h3C), .lapd_valid_i(lval), .lapd_ready_o(lrdy),
    .rx_general_channel_byte_i(gbyte), .rx_gc_valid_i(gval), .rx_nr_byte_i(nbyte),
    .rx_nr_valid_i(nval), .frame_byte_o(fbyte),
    .frame_byte_valid_o(fval), .frame_start_o(fstart));
  terminal_model term (
    .run_i(run), .use_local_i(loc), .nib_mode_i(nsel), .link_clk_o(lclk),
    .local_clk_o(lref), .line_clk_o(lline), .ser_o(ser), .nib_o(nib));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Caller resumes just after a clock edge
  task automatic wb(input logic we, input logic [5:0] idx,
                    input logic [3:0] sel, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= sel;
    wb_dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    check(ack, 1'b1);
    q = dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 4'hF, 32'h0, q);
    check(q, exp);
  endtask

  function automatic logic is_oh(input int s);
    return s inside {FA1_POS, FA2_POS, EM_POS, TR_POS, MA_POS, NR_POS,
                     GC_POS};
  endfunction

  function automatic logic [7:0] slot_byte(input int s,
                                           input logic [7:0] gc);
    if (s == FA1_POS)
      return FA1_VAL;
    if (s == FA2_POS)
      return FA2_VAL;
    if (s == GC_POS)
      return gc;
    return is_oh(s) ? FILL_BYTE : 8'hA5;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [31:0] q;
    rd_chk(CTRL_IDX, {29'h0, CTRL_RST});
    rd_chk(TX_GC_IDX, {24'h0, BYTE_RST});
    wb(1'b1, TX_GC_IDX, 4'hF, 32'h5A, q);
    wb(1'b1, TX_GC_IDX, 4'hE, 32'hC3, q);
    rd_chk(TX_GC_IDX, 32'h5A);
    wb(1'b1, 6'h00, 4'hF, 32'hFF, q);
    rd_chk(6'h00, 32'h0);
    gbyte <= 8'h11;
    gval <= 1'b1;
    nbyte <= 8'h33;
    nval <= 1'b1;
    @(posedge clk_i);
    gbyte <= 8'h22;
    nval <= 1'b0;
    @(posedge clk_i);
    gval <= 1'b0;
    @(posedge clk_i);
    rd_chk(RX_GC_IDX, 32'h22);
    rd_chk(RX_NR_IDX, 32'h33);
  endtask

  // One whole frame; only the first payload slot of the first frame may underrun
  task automatic check_frame(input logic [7:0] gc, input logic nmode,
                             input logic lapd, input logic first);
    int s, w, n_eof, n_rise, n_rdy, n_nfr, n_lp;
    logic prev, prev_lp;
    logic [7:0] e;
    logic [31:0] q;
    n_eof = 0;
    n_rise = 0;
    n_rdy = 0;
    n_nfr = 0;
    n_lp = 0;
    prev = nclk;
    prev_lp = lpclk;
    for (s = 0; s < 537; s++)
    begin
      w = 0;
      do
      begin
        @(posedge clk_i);
        w++;
        n_eof += (eof === 1'b1);
        n_rise += (nclk === 1'b1 && prev !== 1'b1);
        prev = nclk;
        n_rdy += (lrdy === 1'b1);
        n_nfr += (nfr === 1'b1);
        n_lp += (lpclk === 1'b1 && prev_lp !== 1'b1);
        prev_lp = lpclk;
      end
      while (fval !== 1'b1 && w < 200);
      e = slot_byte(s, gc);
      if (first && s == 2 && fbyte === 8'h00)
        e = 8'h00;
      check(fbyte, e);
      check(fstart, s == 0);
      check(warn, is_oh((s + 1) % 537));
      if (first && s == 100)
        wb(1'b1, CTRL_IDX, 4'hF, 32'h1 << CTRL_LAPD_GC, q);
    end
    check(n_eof, 8);
    check(n_rdy, lapd);
    // Last nibble is four bit periods of eight system clocks
    check(n_nfr, nmode ? 32 : 0);
    // Nibble frames run local timed, so the line clock is idle
    check(nmode ? n_lp == 0 : (n_lp >= 4295 && n_lp <= 4297),
          1'b1);
    check(nmode ? (n_rise >= 1073 && n_rise <= 1075) : n_rise == 0,
          1'b1);
  endtask

  // Switch while the link clock is low so no bit is lost
  task automatic test_local_nibble();
    logic [31:0] q;
    while (lclk !== 1'b0)
      @(posedge clk_i);
    nsel <= 1'b1;
    loc <= 1'b1;
    wb(1'b1, CTRL_IDX, 4'hF, 32'h3, q);
    check_frame(8'h3C, 1'b1, 1'b1, 1'b0);
  endtask

  task automatic test_status();
    logic [31:0] q;
    rd_chk(STATUS_IDX, 32'h1 << STAT_UNDERRUN);
    wb(1'b1, STATUS_IDX, 4'hF, 32'h3, q);
    rd_chk(STATUS_IDX, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_regs();
    run <= 1'b1;
    check_frame(8'h5A, 1'b0, 1'b0, 1'b1);
    test_local_nibble();
    test_status();
    give_verdict();
  end

  // Two frames take about 690 us
  initial
  begin
    #900000;
    error_cnt++;
    give_verdict();
  end
endmodule
